// ### csc_flags_pkg.sv
// Constants for the per-socket card status-change flag register
// Summary of operation
// [R1] A flag whose source is disabled always reads as 0.
// [R2] An enabled event sets its flag; it stays set until software clears it.
// [R3] Any set, enabled flag raises the socket's interrupt to the host.
// [R4] Flags clear by a read of the register or by writing 1 to the bit.
// [R5] The global clear-mode bit selects clear-on-read or clear-on-write-one.
// [R6] Bits 7 to 4 read as zero; writes to them do nothing.
// [R7] Bit 3 sets when either card detect pin changes level.
// [R8] Memory card: bit 2 sets on a low-to-high edge of READY.
// [R9] Memory card: bit 1 sets on a battery low warning.
// [R10] I/O card: bits 2 and 1 are held at zero.
// [R11] Bit 0 is battery dead for memory cards, status-change asserted for I/O.
// [R12] With ring function on, bit 0 shows the live ring indicate pin state.
// [R13] Two sockets, each register at 804h, or legacy index 04h and 44h.
// [R14] Each of the four flag sources has its own enable input.
// [R15] Card-type select: 0 memory card, 1 I/O card.
// [R16] Ring function enable turns the battery pin into ring indicate.
// [R17] An event in the same cycle as a clear leaves the flag set.
// [R18] Card pins are synchronised before edge detection; flags reset to 0.
package csc_flags_pkg;
   // Register locations
   localparam logic [11:0] SOCKET_FLAGS_OFFSET = 12'h804;
   localparam logic [11:0] LEGACY_FLAGS_IDX_A = 12'h004;
   localparam logic [11:0] LEGACY_FLAGS_IDX_B = 12'h044;
   localparam int SOCKET_COUNT = 2;
   // Flag bit positions
   localparam int DETECT_CHANGE_BIT = 3;
   localparam int READY_RISE_BIT = 2;
   localparam int BATTERY_LOW_BIT = 1;
   localparam int BATTERY_DEAD_BIT = 0;
   localparam int FLAG_WIDTH = 4;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [3:0] UNUSED_BITS_VALUE = 4'h0;
   // Clear mode encoding of the global control bit
   localparam logic CLEAR_ON_READ = 1'b0;
   localparam logic CLEAR_ON_WRITE_ONE = 1'b1;
   // Synchronised pin vector layout
   localparam int PIN_COUNT = 5;
   localparam int PIN_CD1 = 0;
   localparam int PIN_CD2 = 1;
   localparam int PIN_READY = 2;
   localparam int PIN_BVD1 = 3;
   localparam int PIN_BVD2 = 4;
   localparam logic [4:0] PINS_RESET = 5'h00;
   // Cycles after reset before edges are believed
   localparam logic [1:0] ARM_CYCLES = 2'h3;
   localparam logic [1:0] ARM_RESET = 2'h0;
endpackage

// ### csc_pin_sync.sv
// Two-stage synchroniser for the card socket pins
`timescale 1ns/100ps
module csc_pin_sync
   import csc_flags_pkg::*;
#(
   parameter int WIDTH = PIN_COUNT
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pins_i,
   output logic [WIDTH-1:0] pins_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins_i;
         sync_q <= meta_q;
      end
   end

   assign pins_o = sync_q;
endmodule

// ### card_status_change_flags.sv
// Status-change flag registers and interrupts for both card sockets
`timescale 1ns/100ps
module card_status_change_flags
   import csc_flags_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic host_rd_i,
   input wire logic host_wr_i,
   input wire logic host_legacy_i,
   input wire logic host_socket_i,
   input wire logic [11:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   output logic [7:0] host_rdata_o,
   output logic [1:0] csc_irq_o,
   input wire logic flag_clear_mode_i,
   input wire logic [1:0] detect_change_enable_i,
   input wire logic [1:0] ready_rise_enable_i,
   input wire logic [1:0] battery_low_enable_i,
   input wire logic [1:0] battery_dead_enable_i,
   input wire logic [1:0] io_card_select_i,
   input wire logic [1:0] ring_function_enable_i,
   input wire logic [1:0] card_cd1_n_i,
   input wire logic [1:0] card_cd2_n_i,
   input wire logic [1:0] card_ready_i,
   input wire logic [1:0] card_bvd1_i,
   input wire logic [1:0] card_bvd2_i
);
   logic [1:0] arm_q;
   logic [1:0] arm_d;
   logic armed;
   logic [7:0] visible_all;
   logic [1:0] rd_hit_all;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   // Socket-space or legacy-index decode for one socket
   function automatic logic reg_hit(input logic sock, input logic legacy,
                                    input logic sel, input logic [11:0] addr);
      logic hit;
      hit = 1'b0;
      if (legacy) begin
         hit = (addr == (sock ? LEGACY_FLAGS_IDX_B : LEGACY_FLAGS_IDX_A)); // R13
      end else begin
         hit = (sel == sock) && (addr == SOCKET_FLAGS_OFFSET); // R13
      end
      return hit;
   endfunction

   // Hold off edge detection until the synchronisers are filled
   always_comb begin
      arm_d = arm_q;
      if (arm_q != ARM_CYCLES) begin
         arm_d = arm_q + 2'h1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         arm_q <= ARM_RESET;
      end else begin
         arm_q <= arm_d;
      end
   end

   assign armed = (arm_q == ARM_CYCLES);

   genvar s;
   generate
      for (s = 0; s < SOCKET_COUNT; s++) begin : g_sock
         logic [4:0] pins_raw;
         logic [4:0] pins_sync;
         logic [4:0] prev_q;
         logic [4:0] prev_d;
         logic [3:0] flags_q;
         logic [3:0] flags_d;
         logic [3:0] mask;
         logic [3:0] set_v;
         logic [3:0] clr_v;
         logic [3:0] visible;
         logic rd_hit;
         logic wr_hit;
         logic cd_change;
         logic ready_rise;
         logic warn_start;
         logic dead_start;
         logic io_card;
         logic ring_on;

         assign pins_raw = {card_bvd2_i[s], card_bvd1_i[s], card_ready_i[s],
                            card_cd2_n_i[s], card_cd1_n_i[s]};

         csc_pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .pins_i(pins_raw),
            .pins_o(pins_sync)
         ); // R18

         assign io_card = io_card_select_i[s];
         assign ring_on = ring_function_enable_i[s];
         assign rd_hit = host_rd_i && reg_hit(1'(s), host_legacy_i, host_socket_i, host_addr_i);
         assign wr_hit = host_wr_i && reg_hit(1'(s), host_legacy_i, host_socket_i, host_addr_i);

         // Edge detection, enable gating, clear and set
         always_comb begin
            prev_d = pins_sync;
            cd_change = armed && ((pins_sync[PIN_CD1] ^ prev_q[PIN_CD1]) ||
                                  (pins_sync[PIN_CD2] ^ prev_q[PIN_CD2])); // R7 R18
            ready_rise = armed && pins_sync[PIN_READY] && !prev_q[PIN_READY]; // R8
            warn_start = armed && !pins_sync[PIN_BVD2] && prev_q[PIN_BVD2]; // R9
            dead_start = armed && !pins_sync[PIN_BVD1] && prev_q[PIN_BVD1]; // R11
            mask[DETECT_CHANGE_BIT] = detect_change_enable_i[s]; // R14
            mask[READY_RISE_BIT] = ready_rise_enable_i[s] && !io_card; // R10 R15
            mask[BATTERY_LOW_BIT] = battery_low_enable_i[s] && !io_card; // R10 R15
            mask[BATTERY_DEAD_BIT] = battery_dead_enable_i[s]; // R14
            set_v[DETECT_CHANGE_BIT] = cd_change;
            set_v[READY_RISE_BIT] = ready_rise;
            set_v[BATTERY_LOW_BIT] = warn_start;
            set_v[BATTERY_DEAD_BIT] = dead_start && !ring_on; // R16
            clr_v = 4'h0;
            if (rd_hit && flag_clear_mode_i == CLEAR_ON_READ) begin
               clr_v = 4'hF; // R4 R5
            end else if (wr_hit && flag_clear_mode_i == CLEAR_ON_WRITE_ONE) begin
               clr_v = host_wdata_i[3:0]; // R4 R5 R6
            end
            flags_d = ((flags_q & ~clr_v) | set_v) & mask; // R1 R2 R17
            if (ring_on) begin
               flags_d[BATTERY_DEAD_BIT] = 1'b0;
            end
            visible = flags_q & mask; // R1
            if (ring_on) begin
               visible[BATTERY_DEAD_BIT] = mask[BATTERY_DEAD_BIT] &&
                                           !pins_sync[PIN_BVD1]; // R12 R16
            end
         end

         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               flags_q <= FLAGS_RESET; // R18
               prev_q <= PINS_RESET;
            end else begin
               flags_q <= flags_d;
               prev_q <= prev_d;
            end
         end

         // Interrupt while any visible flag is set
         assign csc_irq_o[s] = |visible; // R3
         assign visible_all[s*4 +: 4] = visible;
         assign rd_hit_all[s] = rd_hit;

         a_disabled_reads_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_hit && !detect_change_enable_i[s] |=> host_rdata_o[3] == 1'b0) // R1
            else $error("disabled detect flag read back as one");
         a_detect_sets_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            cd_change && detect_change_enable_i[s] |=> flags_q[3] ##0 csc_irq_o[s]) // R7
            else $error("detect change did not set flag and interrupt");
         a_flag_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            flags_q[3] && detect_change_enable_i[s] && !rd_hit && !wr_hit
            |=> flags_q[3]) // R2
            else $error("flag dropped without a clear");
         a_event_beats_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            ready_rise && ready_rise_enable_i[s] && !io_card && rd_hit
            |=> flags_q[2]) // R17
            else $error("event lost against a clear");
         a_read_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_hit && flag_clear_mode_i == CLEAR_ON_READ && set_v == 4'h0
            |=> flags_q == 4'h0) // R4
            else $error("read did not clear flags");
         a_write_one_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            wr_hit && flag_clear_mode_i == CLEAR_ON_WRITE_ONE && host_wdata_i[3] && !cd_change
            |=> !flags_q[3]) // R5
            else $error("write of one did not clear flag");
         a_read_keeps_mode1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_hit && flag_clear_mode_i == CLEAR_ON_WRITE_ONE && flags_q[3] &&
            detect_change_enable_i[s] ##1 detect_change_enable_i[s] |-> flags_q[3]) // R5
            else $error("read cleared flag in write-one mode");
         a_io_card_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            io_card |=> io_card |-> flags_q[2:1] == 2'h0) // R10
            else $error("ready or battery flag set with io card");
         a_ring_live: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            ring_on && battery_dead_enable_i[s] && rd_hit
            |=> host_rdata_o[0] == !$past(pins_sync[PIN_BVD1])) // R12
            else $error("ring bit does not follow pin");
      end
   endgenerate

   // Read data latched on every read, unmapped reads return zero
   always_comb begin
      rdata_d = rdata_q;
      if (host_rd_i) begin
         rdata_d = RDATA_RESET;
         if (rd_hit_all[0]) begin
            rdata_d = {UNUSED_BITS_VALUE, visible_all[3:0]}; // R6
         end else if (rd_hit_all[1]) begin
            rdata_d = {UNUSED_BITS_VALUE, visible_all[7:4]}; // R6
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign host_rdata_o = rdata_q;

   a_upper_bits_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      host_rd_i |=> host_rdata_o[7:4] == 4'h0) // R6
      else $error("upper flag bits read nonzero");
endmodule

// ### card_model.sv
// Card model driving the socket pins of both sockets
`timescale 1ns/100ps
module card_model (
   input wire logic clk_sys_i,
   output logic [1:0] cd1_n_o,
   output logic [1:0] cd2_n_o,
   output logic [1:0] ready_o,
   output logic [1:0] bvd1_o,
   output logic [1:0] bvd2_o
);
   // Cards seated, busy, batteries good
   initial begin
      cd1_n_o = 2'h0;
      cd2_n_o = 2'h0;
      ready_o = 2'h0;
      bvd1_o = 2'h3;
      bvd2_o = 2'h3;
   end
   // Flip chosen pins of one socket at the falling edge
   task automatic flip(input int s, input logic [4:0] m);
      @(negedge clk_sys_i);
      cd1_n_o[s] = cd1_n_o[s] ^ m[0];
      cd2_n_o[s] = cd2_n_o[s] ^ m[1];
      ready_o[s] = ready_o[s] ^ m[2];
      bvd1_o[s] = bvd1_o[s] ^ m[3];
      bvd2_o[s] = bvd2_o[s] ^ m[4];
   endtask
endmodule

// ### tb_top.sv
// Testbench for the card status-change flag registers
`timescale 1ns/100ps
module tb_top;
   logic clk_sys_i, rst_i, rd, wr, leg, sock, mode;
   logic [11:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [1:0] irq, en_cd, en_rd, en_bl, en_bd, io, ring, cd1, cd2, rdy, b1, b2;
   int error_cnt, num_checks, cyc;
   card_model i_card (.clk_sys_i(clk_sys_i), .cd1_n_o(cd1), .cd2_n_o(cd2),
      .ready_o(rdy), .bvd1_o(b1), .bvd2_o(b2));
   card_status_change_flags i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .host_rd_i(rd), .host_wr_i(wr), .host_legacy_i(leg), .host_socket_i(sock),
      .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
      .csc_irq_o(irq), .flag_clear_mode_i(mode), .detect_change_enable_i(en_cd),
      .ready_rise_enable_i(en_rd), .battery_low_enable_i(en_bl),
      .battery_dead_enable_i(en_bd), .io_card_select_i(io),
      .ring_function_enable_i(ring), .card_cd1_n_i(cd1), .card_cd2_n_i(cd2),
      .card_ready_i(rdy), .card_bvd1_i(b1), .card_bvd2_i(b2));
   // Clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One host access; read data taken after the strobe edge
   task automatic acc(input logic w, input logic l, input logic s, input logic [11:0] a,
                      input logic [7:0] v);
      @(negedge clk_sys_i);
      rd = ~w;
      wr = w;
      leg = l;
      sock = s;
      addr = a;
      wdata = v;
      @(negedge clk_sys_i);
      rd = 1'b0;
      wr = 1'b0;
      d = rdata;
   endtask
   task automatic rchk(input logic l, input logic s, input logic [11:0] a,
                       input logic [7:0] exp);
      acc(1'b0, l, s, a, 8'h00);
      chk("flags", d, exp);
   endtask
   task automatic ev(input int s, input logic [4:0] m);
      i_card.flip(s, m);
      repeat (4) @(negedge clk_sys_i);
   endtask
   task automatic done(input string name);
      $display("Test %s done", name);
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      {rd, wr, leg, sock, mode, addr, wdata} = '0;
      {en_cd, en_rd, en_bl, en_bd, io, ring} = '0;
      rst_i = 1'b1;
      repeat (16) @(negedge clk_sys_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      rchk(1'b0, 1'b0, 12'h804, 8'h00);
      ev(0, 5'h01);
      chk("irq", {6'h00, irq}, 8'h00);
      rchk(1'b0, 1'b0, 12'h804, 8'h00);
      done("disabled");
      {en_cd, en_rd, en_bl, en_bd} = 8'hFF;
      ev(0, 5'h01);
      chk("irq", {6'h00, irq}, 8'h01);
      rchk(1'b0, 1'b0, 12'h804, 8'h08);
      rchk(1'b0, 1'b0, 12'h804, 8'h00);
      ev(0, 5'h1E);
      rchk(1'b0, 1'b1, 12'h804, 8'h00);
      rchk(1'b0, 1'b0, 12'h804, 8'h0F);
      // READY rise lands in the same cycle as a clearing read
      ev(0, 5'h04);
      i_card.flip(0, 5'h04);
      @(negedge clk_sys_i);
      acc(1'b0, 1'b0, 1'b0, 12'h804, 8'h00);
      chk("race", d, 8'h00);
      rchk(1'b0, 1'b0, 12'h804, 8'h04);
      done("clear_on_read");
      mode = 1'b1;
      ev(0, 5'h01);
      rchk(1'b0, 1'b0, 12'h804, 8'h08);
      rchk(1'b1, 1'b0, 12'h004, 8'h08);
      acc(1'b1, 1'b0, 1'b0, 12'h804, 8'hF7);
      rchk(1'b0, 1'b0, 12'h804, 8'h08);
      acc(1'b1, 1'b0, 1'b0, 12'h804, 8'h08);
      rchk(1'b0, 1'b0, 12'h804, 8'h00);
      chk("irq", {6'h00, irq}, 8'h00);
      done("write_one");
      io = 2'h2;
      ev(1, 5'h14);
      rchk(1'b1, 1'b0, 12'h044, 8'h00);
      ev(1, 5'h08);
      rchk(1'b1, 1'b0, 12'h044, 8'h01);
      chk("irq", {6'h00, irq}, 8'h02);
      acc(1'b1, 1'b1, 1'b0, 12'h044, 8'h01);
      rchk(1'b1, 1'b0, 12'h044, 8'h00);
      done("io_card");
      ring = 2'h1;
      repeat (4) @(negedge clk_sys_i);
      rchk(1'b0, 1'b0, 12'h804, 8'h01);
      ev(0, 5'h08);
      rchk(1'b0, 1'b0, 12'h804, 8'h00);
      rchk(1'b0, 1'b0, 12'h805, 8'h00);
      done("ring");
      end_of_test();
   end
endmodule
